/* common/timer_pkg.sv */
package timer_pkg;

   typedef enum logic [4:0] {
      M_SW_GATE = 5'h00,
      M_GATE_HI = 5'h01,
      M_GATE_LO = 5'h02,
      M_EDGE_ANY = 5'h03,
      M_EDGE_RISE = 5'h04,
      M_EDGE_FALL = 5'h05,
      M_LVL_LO = 5'h06,
      M_LVL_HI = 5'h07,
      M_OS_SW = 5'h08,
      M_OS_RISE = 5'h09,
      M_OS_FALL = 5'h0A,
      M_OS_ANY = 5'h0B
   } mode_t;

   typedef logic [7:0] count_t;

endpackage

/* common/timer_regs.svh */
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// Register byte offsets
`define OFS_COUNT 8'h00
`define OFS_PERIOD 8'h04
`define OFS_CTRL 8'h08
`define OFS_COMPARE 8'h0C
`define OFS_STATUS 8'h10

// Control word fields
`define CTRL_ON_BIT 7
`define CTRL_MODE_LSB 8
`define CTRL_MODE_MSB 12
`define CTRL_DIV_LSB 16
`define CTRL_DIV_MSB 23

// Status word fields
`define STAT_EXT_BIT 0
`define STAT_RUN_BIT 1
`define STAT_ARMED_BIT 2
`define STAT_PWM_BIT 3

// Reset values
`define RST_COUNT 8'h00
`define RST_PERIOD 8'hFF
`define RST_COMPARE 8'h00
`define RST_DIV 8'h00

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* rtl/hlt_timer.sv */
// Operation
// (RL1) Software gate: count while enabled, else hold
// (RL2) Free-run: period match returns count to zero
// (RL3) Hardware gate stops on external high/low
// (RL4) Gate hold stretches PWM period and duty
// (RL5) Edge modes reset counter on chosen edge
// (RL6) Early edge reset restarts PWM, two-clock delay
// (RL7) Level modes hold counter reset on level
// (RL8) Level mode ignores external signal when disabled
// (RL9) Level clear at match or two clocks later
// (RL10) Level resume after match or release delay
// (RL11) Level PWM high from start to compare
// (RL12) Software one-shot: match resets, clears enable
// (RL13) Software restarts each one-shot; pause resumes
// (RL14) New one-shot only after enable set again
// (RL15) One-shot PWM from enable to compare match
// (RL16) Edge one-shot starts on chosen edge
// (RL17) Re-enabled edge one-shot needs fresh edge
// (RL18) Edge one-shot PWM off at period halt
// (RL19) Enable and external pass two-stage synchroniser
// (RL20) One-shot match: clear enable, stop at zero
// (RL21) Counter eight bits, read/write, resets zero
// (RL22) Hardware enable clear visible to next read
// (RL23) Edges found against previous synchronised sample
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "timer_regs.svh"

module hlt_timer
   import timer_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int DIV_W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ext_reset_signal,
   output logic pwm_out,
   output logic pwm_period_set,
   output logic postscaled_match
);
   generate
      if (ADDR_W < 5 || ADDR_W > 32 || DIV_W != 8) begin : g_bad
         $error("hlt_timer: unsupported ADDR_W or DIV_W");
      end
   endgenerate
   // Timer state
   count_t count_q, count_d, period_q, period_d, compare_q, compare_d;
   logic on_q, on_d;
   mode_t mode_q, mode_d;
   logic [DIV_W-1:0] div_q, div_d, div_cnt_q, div_cnt_d;
   logic on_s1_q, on_s1_d, on_s2_q, on_s2_d;
   logic ers_s1_q, ers_s1_d, ers_s2_q, ers_s2_d, ers_p_q, ers_p_d;
   logic armed_q, armed_d, run_p_q, run_p_d;
   logic pwm_q, pwm_d, pset_q, pset_d, match_q, match_d;
   // Bus state
   logic aw_free_q, aw_free_d, w_free_q, w_free_d, ar_free_q, ar_free_d;
   logic [ADDR_W-1:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic tick, run, rst, oneshot, edge_hit, rise, fall, pmatch;
   logic do_wr, wr_count, wr_ctrl, wr_hit;
   logic [31:0] old_word, new_word, mask;
   logic [7:0] waddr8;
   function automatic logic [31:0] reg_word(input logic [7:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (a)
         `OFS_COUNT: v[7:0] = count_q;
         `OFS_PERIOD: v[7:0] = period_q;
         `OFS_COMPARE: v[7:0] = compare_q;
         `OFS_CTRL: begin
            v[`CTRL_ON_BIT] = on_q; // RL22
            v[`CTRL_MODE_MSB:`CTRL_MODE_LSB] = mode_q;
            v[`CTRL_DIV_MSB:`CTRL_DIV_LSB] = div_q;
         end
         `OFS_STATUS: begin
            v[`STAT_EXT_BIT] = ers_s2_q;
            v[`STAT_RUN_BIT] = run_p_q;
            v[`STAT_ARMED_BIT] = armed_q;
            v[`STAT_PWM_BIT] = pwm_q;
         end
         default: v = 32'h0000_0000;
      endcase
      return v;
   endfunction
   function automatic logic reg_mapped(input logic [7:0] a);
      return a == `OFS_COUNT || a == `OFS_PERIOD || a == `OFS_CTRL ||
             a == `OFS_COMPARE || a == `OFS_STATUS;
   endfunction
   // Bus slave; a write happens once address and data are both held and no write response is pending
   always_comb begin
      aw_free_d = aw_free_q;
      w_free_d = w_free_q;
      ar_free_d = ar_free_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      waddr8 = 8'(awaddr_q);
      if (aw_free_q && s_axi_awvalid) begin
         aw_free_d = 1'b0;
         awaddr_d = s_axi_awaddr;
      end
      if (w_free_q && s_axi_wvalid) begin
         w_free_d = 1'b0;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      do_wr = !aw_free_q && !w_free_q && !bvalid_q;
      if (do_wr) begin
         aw_free_d = 1'b1;
         w_free_d = 1'b1;
         bvalid_d = 1'b1;
         bresp_d = reg_mapped(waddr8) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (ar_free_q && s_axi_arvalid) begin
         ar_free_d = 1'b0;
         rvalid_d = 1'b1;
         rdata_d = reg_word(8'(s_axi_araddr));
         rresp_d = reg_mapped(8'(s_axi_araddr)) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
         ar_free_d = 1'b1;
      end
      mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}},
              {8{wstrb_q[0]}}};
      old_word = reg_word(waddr8);
      new_word = (old_word & ~mask) | (wdata_q & mask);
      wr_hit = do_wr && reg_mapped(waddr8);
      wr_count = wr_hit && waddr8 == `OFS_COUNT;
      wr_ctrl = wr_hit && waddr8 == `OFS_CTRL;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_free_q <= 1'b1;
         w_free_q <= 1'b1;
         ar_free_q <= 1'b1;
         awaddr_q <= '0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q <= `RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end else begin
         aw_free_q <= aw_free_d;
         w_free_q <= w_free_d;
         ar_free_q <= ar_free_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end
   // Timer core; tick is the divided timer clock enable
   always_comb begin
      count_d = count_q;
      period_d = period_q;
      compare_d = compare_q;
      on_d = on_q;
      mode_d = mode_q;
      div_d = div_q;
      on_s1_d = on_s1_q;
      on_s2_d = on_s2_q;
      ers_s1_d = ers_s1_q;
      ers_s2_d = ers_s2_q;
      ers_p_d = ers_p_q;
      armed_d = armed_q;
      run_p_d = run_p_q;
      pwm_d = pwm_q;
      run = 1'b0;
      rst = 1'b0;
      oneshot = 1'b0;
      tick = div_cnt_q == div_q;
      div_cnt_d = tick ? '0 : div_cnt_q + 1'b1;
      rise = ers_s2_q && !ers_p_q; // RL23
      fall = !ers_s2_q && ers_p_q; // RL23
      pmatch = count_q == period_q;
      case (mode_q)
         M_EDGE_ANY, M_OS_ANY: edge_hit = rise || fall;
         M_EDGE_RISE, M_OS_RISE: edge_hit = rise;
         M_EDGE_FALL, M_OS_FALL: edge_hit = fall;
         default: edge_hit = 1'b0;
      endcase
      case (mode_q)
         M_SW_GATE: run = on_s2_q; // RL1
         M_GATE_HI: run = on_s2_q && !ers_s2_q; // RL3 RL4
         M_GATE_LO: run = on_s2_q && ers_s2_q; // RL3 RL4
         M_EDGE_ANY, M_EDGE_RISE, M_EDGE_FALL: begin
            run = on_s2_q;
            rst = on_s2_q && edge_hit; // RL5
         end
         // Reset level only counts while enabled
         M_LVL_LO: begin
            run = on_s2_q && ers_s2_q; // RL8 RL10
            rst = on_s2_q && !ers_s2_q; // RL7 RL9
         end
         M_LVL_HI: begin
            run = on_s2_q && !ers_s2_q; // RL8 RL10
            rst = on_s2_q && ers_s2_q; // RL7 RL9
         end
         M_OS_SW: begin
            run = on_s2_q; // RL13
            oneshot = 1'b1;
         end
         M_OS_RISE, M_OS_FALL, M_OS_ANY: begin
            run = on_s2_q && armed_q; // RL16
            oneshot = 1'b1;
         end
         default: run = 1'b0;
      endcase
      pset_d = tick && run && pmatch && !rst;
      match_d = pset_d;
      if (tick) begin
         // Two timer clocks from enable/pin to the counter
         on_s1_d = on_q; // RL19
         on_s2_d = on_s1_q; // RL19
         ers_s1_d = ext_reset_signal; // RL19
         ers_s2_d = ers_s1_q; // RL19
         ers_p_d = ers_s2_q;
         run_p_d = run;
         if (!on_s2_q) begin
            armed_d = 1'b0; // RL17
         end else if (edge_hit) begin
            armed_d = 1'b1; // RL16
         end
         if (run && compare_q == count_q && !rst) begin
            pwm_d = 1'b0; // RL11 RL15 RL18
         end
         if (rst) begin
            count_d = `RST_COUNT; // RL5 RL7
            pwm_d = pwm_q || edge_hit; // RL6
         end else if (run) begin
            if (pmatch) begin
               count_d = `RST_COUNT; // RL2 RL20
               if (oneshot) begin
                  // Stop at once instead of waiting out the sync
                  on_d = 1'b0; // RL12 RL14 RL20
                  on_s1_d = 1'b0;
                  on_s2_d = 1'b0;
                  armed_d = 1'b0;
               end else begin
                  pwm_d = 1'b1; // RL2
               end
            end else begin
               count_d = count_q + 1'b1; // RL1
               if (!run_p_q && count_q == `RST_COUNT) begin
                  pwm_d = 1'b1; // RL11 RL15 RL18
               end
            end
         end
      end
      if (wr_count) begin
         count_d = new_word[7:0]; // RL21
      end
      if (wr_hit && waddr8 == `OFS_PERIOD) begin
         period_d = new_word[7:0];
      end
      if (wr_hit && waddr8 == `OFS_COMPARE) begin
         compare_d = new_word[7:0];
      end
      // A software write of the enable wins over the hardware clear
      if (wr_ctrl) begin
         on_d = new_word[`CTRL_ON_BIT]; // RL13
         mode_d = mode_t'(new_word[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
         div_d = new_word[`CTRL_DIV_MSB:`CTRL_DIV_LSB];
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= `RST_COUNT; // RL21
         period_q <= `RST_PERIOD;
         compare_q <= `RST_COMPARE;
         on_q <= 1'b0;
         mode_q <= M_SW_GATE;
         div_q <= `RST_DIV;
         div_cnt_q <= '0;
         on_s1_q <= 1'b0;
         on_s2_q <= 1'b0;
         ers_s1_q <= 1'b0;
         ers_s2_q <= 1'b0;
         ers_p_q <= 1'b0;
         armed_q <= 1'b0;
         run_p_q <= 1'b0;
         pwm_q <= 1'b0;
         pset_q <= 1'b0;
         match_q <= 1'b0;
      end else begin
         count_q <= count_d;
         period_q <= period_d;
         compare_q <= compare_d;
         on_q <= on_d;
         mode_q <= mode_d;
         div_q <= div_d;
         div_cnt_q <= div_cnt_d;
         on_s1_q <= on_s1_d;
         on_s2_q <= on_s2_d;
         ers_s1_q <= ers_s1_d;
         ers_s2_q <= ers_s2_d;
         ers_p_q <= ers_p_d;
         armed_q <= armed_d;
         run_p_q <= run_p_d;
         pwm_q <= pwm_d;
         pset_q <= pset_d;
         match_q <= match_d;
      end
   end
   assign s_axi_awready = aw_free_q;
   assign s_axi_wready = w_free_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = ar_free_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign pwm_out = pwm_q;
   assign pwm_period_set = pset_q;
   assign postscaled_match = match_q;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_sw_gate_hold: assert property ( // RL1
      tick && mode_q == M_SW_GATE && !on_s2_q && !wr_count
      |=> $stable(count_q))
      else $error("count moved while disabled");
   a_free_wrap: assert property ( // RL2
      tick && mode_q == M_SW_GATE && on_s2_q && pmatch && !wr_count
      |=> count_q == 8'h00 ##0 postscaled_match)
      else $error("no wrap to zero at period match");
   a_gate_stop: assert property ( // RL3
      tick && mode_q == M_GATE_HI && ers_s2_q && !wr_count
      |=> $stable(count_q))
      else $error("gate high did not stop counter");
   a_edge_reset: assert property ( // RL5
      tick && mode_q == M_EDGE_RISE && on_s2_q && rise && !wr_count
      |=> count_q == 8'h00)
      else $error("rising edge did not reset counter");
   a_level_hold: assert property ( // RL7
      tick && mode_q == M_LVL_HI && on_s2_q && ers_s2_q && !wr_count
      |=> count_q == 8'h00)
      else $error("high level did not hold reset");
   a_level_ignore: assert property ( // RL8
      tick && mode_q == M_LVL_HI && !on_s2_q && !wr_count
      |=> $stable(count_q))
      else $error("level reset acted while disabled");
   a_oneshot_end: assert property ( // RL12
      tick && mode_q == M_OS_SW && run && pmatch && !wr_ctrl && !wr_count
      |=> !on_q && count_q == 8'h00 ##1 $stable(count_q))
      else $error("one-shot did not stop at zero");
   a_edge_wait: assert property ( // RL16
      tick && mode_q == M_OS_RISE && !armed_q && !wr_count
      |=> $stable(count_q))
      else $error("edge one-shot ran before its edge");
   a_pwm_fall: assert property ( // RL11
      $fell(pwm_q) |-> $past(count_q == compare_q))
      else $error("pwm dropped away from compare match");
   a_sync_path: assert property ( // RL19
      $rose(on_s2_q) |-> $past(on_s1_q))
      else $error("enable skipped a synchroniser stage");

endmodule

/* test/ext_model.sv */
`timescale 1ns/100ps
module ext_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic level_req,
   input wire logic pwm_period_set,
   output logic ext_reset_signal,
   output logic [31:0] period_count
);
   logic [31:0] period_count_d;

   always_comb begin
      period_count_d = period_count;
      if (pwm_period_set === 1'b1) begin
         period_count_d = period_count + 32'h1;
      end
   end

   // Level moves only on clock edges and is held for many ticks, so the
   // two-stage synchroniser inside the timer never misses a change
   always_ff @(posedge aclk) begin
      ext_reset_signal <= level_req;
      if (!aresetn) begin
         period_count <= 32'h0;
      end else begin
         period_count <= period_count_d;
      end
   end
endmodule

/* test/tb_top.sv */
`timescale 1ns/100ps
`include "timer_regs.svh"
module tb_top;
   import timer_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, ext_level, ext, pwm, pset, pscal;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, pcnt, v;
   logic [1:0] bresp, rresp, r;
   int errors, comparisons;
   int pscal_n = 0;
   int pwm_n = 0;

   hlt_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .ext_reset_signal(ext), .pwm_out(pwm),
      .pwm_period_set(pset), .postscaled_match(pscal));

   ext_model partner (.aclk(aclk), .aresetn(aresetn), .level_req(ext_level),
      .pwm_period_set(pset), .ext_reset_signal(ext), .period_count(pcnt));

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   // Non-blocking counts, so a window read right after an edge is stable
   always @(posedge aclk) begin
      if (pscal === 1'b1) begin
         pscal_n <= pscal_n + 1;
      end
      if (pwm === 1'b1) begin
         pwm_n <= pwm_n + 1;
      end
   end

   task automatic tally_and_finish();
      if (errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h, want %h", $time, got, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            done = 1'b1;
            bready <= 1'b0;
            cmp_word({30'h0, bresp}, {30'h0, er});
         end
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] rr);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            done = 1'b1;
            d = rdata;
            rr = rresp;
            rready <= 1'b0;
         end
      end
   endtask

   task automatic chk(input logic [7:0] a, input logic [31:0] exp,
                      input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] rr;
      rd(a, d, rr);
      cmp_word(d, exp);
      cmp_word({30'h0, rr}, {30'h0, er});
   endtask

   // Period pulses seen over 60 cycles; with PERIOD 5 the wrap is 6 cycles
   task automatic win(input logic [31:0] exp);
      logic [31:0] c0;
      int p0;
      c0 = pcnt;
      p0 = pscal_n;
      wt(60);
      cmp_word(pcnt - c0, exp);
      cmp_word(32'(pscal_n - p0), exp);
   endtask

   // Drive-high cycles over 60; compare 3 in a 6-cycle period keeps the
   // drive up from count 0 until the match at count 3
   task automatic duty(input logic [31:0] exp);
      int w0;
      w0 = pwm_n;
      wt(60);
      cmp_word(32'(pwm_n - w0), exp);
   endtask

   // Count sits above 100 before the edge; an early reset brings it low
   task automatic edge_chk(input logic [4:0] m, input logic lvl);
      wr(`OFS_CTRL, {19'h0, m, 8'h80}, `RESP_OKAY);
      wt(100);
      ext_level <= lvl;
      wt(8);
      rd(`OFS_COUNT, v, r);
      cmp_word({31'h0, v < 32'hC}, 32'h1);
   endtask

   initial begin
      #160000;
      errors++;
      tally_and_finish();
   end

   initial begin
      aresetn = 1'b0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      ext_level = 1'b0;
      errors = 0;
      comparisons = 0;
      wt(3);
      aresetn <= 1'b1;
      chk(`OFS_COUNT, 32'h0, `RESP_OKAY);
      chk(`OFS_PERIOD, 32'hFF, `RESP_OKAY);
      chk(`OFS_CTRL, 32'h0, `RESP_OKAY);
      chk(`OFS_COMPARE, 32'h0, `RESP_OKAY);
      chk(`OFS_STATUS, 32'h0, `RESP_OKAY);
      chk(8'h14, 32'h0, `RESP_SLVERR);
      wr(8'h14, 32'h1, `RESP_SLVERR);
      for (int m = 0; m < 12; m++) begin
         wr(`OFS_CTRL, 32'(m) << 8, `RESP_OKAY);
         chk(`OFS_CTRL, 32'(m) << 8, `RESP_OKAY);
      end
      wr(`OFS_COUNT, 32'h21, `RESP_OKAY);
      wt(20);
      chk(`OFS_COUNT, 32'h21, `RESP_OKAY);
      wr(`OFS_PERIOD, 32'h5, `RESP_OKAY);
      // A count above the period would run on to the 8-bit wrap first
      wr(`OFS_COUNT, 32'h0, `RESP_OKAY);
      wr(`OFS_COMPARE, 32'h3, `RESP_OKAY);
      wr(`OFS_CTRL, 32'h80, `RESP_OKAY);
      wt(20);
      win(32'd10);
      duty(32'd40);
      ext_level <= 1'b1;
      wr(`OFS_CTRL, 32'h180, `RESP_OKAY);
      wt(10);
      win(32'd0);
      ext_level <= 1'b0;
      wt(10);
      win(32'd10);
      wr(`OFS_CTRL, 32'h280, `RESP_OKAY);
      wt(10);
      win(32'd0);
      ext_level <= 1'b1;
      wr(`OFS_CTRL, 32'h780, `RESP_OKAY);
      wt(10);
      win(32'd0);
      chk(`OFS_COUNT, 32'h0, `RESP_OKAY);
      wr(`OFS_CTRL, 32'h680, `RESP_OKAY);
      wt(10);
      win(32'd10);
      duty(32'd40);
      wr(`OFS_CTRL, 32'h700, `RESP_OKAY);
      wr(`OFS_COUNT, 32'h44, `RESP_OKAY);
      wt(10);
      chk(`OFS_COUNT, 32'h44, `RESP_OKAY);
      ext_level <= 1'b0;
      wr(`OFS_PERIOD, 32'hFF, `RESP_OKAY);
      edge_chk(5'h04, 1'b1);
      edge_chk(5'h05, 1'b0);
      edge_chk(5'h03, 1'b1);
      wr(`OFS_PERIOD, 32'h5, `RESP_OKAY);
      wr(`OFS_COUNT, 32'h0, `RESP_OKAY);
      wr(`OFS_CTRL, 32'h880, `RESP_OKAY);
      wt(30);
      chk(`OFS_CTRL, 32'h800, `RESP_OKAY);
      chk(`OFS_COUNT, 32'h0, `RESP_OKAY);
      wr(`OFS_CTRL, 32'h880, `RESP_OKAY);
      wt(30);
      chk(`OFS_CTRL, 32'h800, `RESP_OKAY);
      ext_level <= 1'b0;
      wr(`OFS_CTRL, 32'h980, `RESP_OKAY);
      wt(30);
      chk(`OFS_CTRL, 32'h980, `RESP_OKAY);
      chk(`OFS_COUNT, 32'h0, `RESP_OKAY);
      ext_level <= 1'b1;
      wt(30);
      chk(`OFS_CTRL, 32'h900, `RESP_OKAY);
      chk(`OFS_COUNT, 32'h0, `RESP_OKAY);
      wr(`OFS_CTRL, 32'h980, `RESP_OKAY);
      wt(30);
      chk(`OFS_CTRL, 32'h980, `RESP_OKAY);
      ext_level <= 1'b0;
      wt(30);
      chk(`OFS_CTRL, 32'h980, `RESP_OKAY);
      // Codes above the documented set must leave the counter frozen
      wr(`OFS_CTRL, 32'hC80, `RESP_OKAY);
      wr(`OFS_COUNT, 32'h33, `RESP_OKAY);
      wt(30);
      chk(`OFS_COUNT, 32'h33, `RESP_OKAY);
      win(32'd0);
      tally_and_finish();
   end
endmodule
